// ===== tci_pkg.sv
// Shared constants and types for the Type-C interrupt and ident block
package tci_pkg;

  // ****************************************************************
  // Control byte layout and reset values
  // ****************************************************************
  localparam logic [7:0] TCI_CTRL_RST      = 8'h03;
  localparam logic [7:0] TCI_MODE_RST      = 8'h04;
  localparam int         TCI_CTRL_MASK_BIT = 0;
  localparam int         TCI_CTRL_CUR_LO   = 1;
  localparam int         TCI_CTRL_CUR_HI   = 2;

  // ****************************************************************
  // Attached-type byte and mode byte fields
  // ****************************************************************
  localparam int TCI_TYPE_SINK_BIT = 4;
  localparam int TCI_MODE_SRC_BIT  = 0;
  localparam int TCI_MODE_SRCA_BIT = 1;

  // ****************************************************************
  // Slave address byte, select pin lands on bit 3
  // ****************************************************************
  localparam logic [7:0] TCI_ADDR_BASE    = 8'h42;
  localparam int         TCI_ADDR_SEL_BIT = 3;

  // ****************************************************************
  // Interrupt flag positions
  // ****************************************************************
  localparam int TCI_IRQ_W      = 5;
  localparam int TCI_IRQ_ATTACH = 0;
  localparam int TCI_IRQ_DETACH = 1;
  localparam int TCI_IRQ_BC_LVL = 2;
  localparam int TCI_IRQ_ACC_CH = 3;
  localparam int TCI_IRQ_VBUS   = 4;

  // ****************************************************************
  // Source current advertisement codes
  // ****************************************************************
  typedef enum logic [1:0] {
    TCI_CUR_NONE = 2'h0,
    TCI_CUR_DEF  = 2'h1,
    TCI_CUR_1A5  = 2'h2,
    TCI_CUR_3A   = 2'h3
  } tci_cur_t;

endpackage : tci_pkg

// ===== tci_sync.sv
// Two-stage synchroniser for asynchronous level inputs
`timescale 1ns/1ps
module tci_sync #(
  parameter int W = 1
) (
  input  wire logic         clk_i,
  input  wire logic         rst_n_i,
  input  wire logic [W-1:0] async_i,
  output logic      [W-1:0] sync_o
);

  // ****************************************************************
  // First stage is read only by the second
  // ****************************************************************
  logic [W-1:0] meta;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      meta   <= '0;
      sync_o <= '0;
    end else begin
      meta   <= async_i;
      sync_o <= meta;
    end
  end

endmodule : tci_sync

// ===== tci_flags.sv
// Sticky interrupt flag bank, set wins over clear
`timescale 1ns/1ps
module tci_flags #(
  parameter int W = 5
) (
  input  wire logic         clk_i,
  input  wire logic         rst_n_i,
  input  wire logic [W-1:0] set_i,
  input  wire logic [W-1:0] clr_i,
  output logic      [W-1:0] flags_o
);

  // ****************************************************************
  // Flag storage
  // ****************************************************************
  logic [W-1:0] next_flags;

  always_comb begin
    // Event in the clearing cycle survives
    next_flags = (flags_o & ~clr_i) | set_i;
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      flags_o <= '0;
    end else begin
      flags_o <= next_flags;
    end
  end

endmodule : tci_flags

// ===== tci_irq_ident.sv
// Interrupt output, role ident, address select and current select logic
`timescale 1ns/1ps
module tci_irq_ident
  import tci_pkg::*;
(
  input  wire logic           clk_i,
  input  wire logic           rst_n_i,
  input  wire logic           ctrl_wr_i,
  input  wire logic [7:0]     ctrl_wdata_i,
  input  wire logic           mode_wr_i,
  input  wire logic [7:0]     mode_wdata_i,
  input  wire logic [TCI_IRQ_W-1:0] src_mask_i,
  input  wire logic           int_read_i,
  input  wire logic           attach_evt_i,
  input  wire logic           detach_evt_i,
  input  wire logic           bc_lvl_evt_i,
  input  wire logic           acc_ch_evt_i,
  input  wire logic           source_role_i,
  input  wire logic [7:0]     type_reg_i,
  input  wire logic           vbus_above_thr_i,
  input  wire logic           addr_select_pin_i,
  output logic [7:0]          ctrl_o,
  output logic [7:0]          mode_o,
  output logic [TCI_IRQ_W-1:0] int_flags_o,
  output logic                int_n_o,
  output logic                int_oe_o,
  output logic                role_ident_out_o,
  output logic                role_ident_out_oe_o,
  output logic [7:0]          slave_addr_o,
  output tci_cur_t            cc_current_adv_o,
  output tci_cur_t            rd_thr_sel_o,
  output logic                vbus_valid_irq_o
);

  // ****************************************************************
  // Reset release
  // ****************************************************************
  logic rst_meta;
  logic rst_n;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  logic [1:0] pins_sync;
  logic       vbus_s;
  logic       addr_s;

  tci_sync #(
    .W (2)
  ) u_sync (
    .clk_i   (clk_i),
    .rst_n_i (rst_n),
    .async_i ({vbus_above_thr_i, addr_select_pin_i}),
    .sync_o  (pins_sync)
  );

  assign vbus_s = pins_sync[1];
  assign addr_s = pins_sync[0];

  // ****************************************************************
  // Control and mode bytes
  // ****************************************************************
  logic [7:0] next_ctrl;
  logic [7:0] next_mode;

  always_comb begin
    next_ctrl = ctrl_o;
    next_mode = mode_o;
    // Host order of role then unmask is its own duty
    if (ctrl_wr_i) begin
      next_ctrl = ctrl_wdata_i;
    end
    if (mode_wr_i) begin
      next_mode = mode_wdata_i;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_o <= TCI_CTRL_RST;
      mode_o <= TCI_MODE_RST;
    end else begin
      ctrl_o <= next_ctrl;
      mode_o <= next_mode;
    end
  end

  // ****************************************************************
  // VBUS valid event
  // ****************************************************************
  logic vbus_prev;
  logic next_vbus_prev;
  logic vbus_rise;
  logic next_vbus_irq;

  always_comb begin
    next_vbus_prev = vbus_s;
    vbus_rise      = vbus_s & ~vbus_prev;
    next_vbus_irq  = vbus_rise;
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      vbus_prev        <= 1'b0;
      vbus_valid_irq_o <= 1'b0;
    end else begin
      vbus_prev        <= next_vbus_prev;
      vbus_valid_irq_o <= next_vbus_irq;
    end
  end

  // ****************************************************************
  // Sticky flags
  // ****************************************************************
  logic [TCI_IRQ_W-1:0] flag_set;
  logic [TCI_IRQ_W-1:0] flag_clr;

  always_comb begin
    flag_set                 = '0;
    flag_set[TCI_IRQ_ATTACH] = attach_evt_i;
    flag_set[TCI_IRQ_DETACH] = detach_evt_i;
    flag_set[TCI_IRQ_BC_LVL] = bc_lvl_evt_i;
    flag_set[TCI_IRQ_ACC_CH] = acc_ch_evt_i;
    flag_set[TCI_IRQ_VBUS]   = vbus_rise;
    // Reading clears what was seen, even under global mask
    flag_clr = int_read_i ? int_flags_o : '0;
  end

  tci_flags #(
    .W (TCI_IRQ_W)
  ) u_flags (
    .clk_i   (clk_i),
    .rst_n_i (rst_n),
    .set_i   (flag_set),
    .clr_i   (flag_clr),
    .flags_o (int_flags_o)
  );

  // ****************************************************************
  // Interrupt pin
  // ****************************************************************
  logic next_int_oe;

  always_comb begin
    // Only real pending events pull low, never the unmask itself
    next_int_oe = ~ctrl_o[TCI_CTRL_MASK_BIT] &
                  (|(int_flags_o & ~src_mask_i));
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      int_oe_o <= 1'b0;
      int_n_o  <= 1'b0;
    end else begin
      int_oe_o <= next_int_oe;
      int_n_o  <= 1'b0;
    end
  end

  // ****************************************************************
  // Role ident, address and current select
  // ****************************************************************
  logic       next_id_oe;
  logic [7:0] next_addr;
  tci_cur_t   next_adv;
  tci_cur_t   next_thr;

  always_comb begin
    next_id_oe = type_reg_i[TCI_TYPE_SINK_BIT];
    next_addr  = TCI_ADDR_BASE;
    next_addr[TCI_ADDR_SEL_BIT] = addr_s;
    // Field 00 is not a valid choice; advertise nothing then
    next_thr = tci_cur_t'({ctrl_o[TCI_CTRL_CUR_HI],
                           ctrl_o[TCI_CTRL_CUR_LO]});
    next_adv = source_role_i ? next_thr : TCI_CUR_NONE;
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      role_ident_out_oe_o <= 1'b0;
      role_ident_out_o    <= 1'b0;
      slave_addr_o        <= TCI_ADDR_BASE;
      cc_current_adv_o    <= TCI_CUR_NONE;
      rd_thr_sel_o        <= TCI_CUR_DEF;
    end else begin
      role_ident_out_oe_o <= next_id_oe;
      role_ident_out_o    <= 1'b0;
      slave_addr_o        <= next_addr;
      cc_current_adv_o    <= next_adv;
      rd_thr_sel_o        <= next_thr;
    end
  end

endmodule : tci_irq_ident

// ===== tci_irq_ident_properties.sv
// Checker for the interrupt, ident and address outputs
`timescale 1ns/1ps
module tci_irq_ident_properties
  import tci_pkg::*;
(
  input wire logic       clk_i,
  input wire logic       rst_n_i,
  input wire logic [7:0] ctrl_o,
  input wire logic [7:0] mode_o,
  input wire logic [4:0] int_flags_o,
  input wire logic [4:0] src_mask_i,
  input wire logic       int_oe_o,
  input wire logic       int_n_o,
  input wire logic [7:0] type_reg_i,
  input wire logic       role_ident_out_oe_o,
  input wire logic       addr_select_pin_i,
  input wire logic [7:0] slave_addr_o,
  input wire logic       vbus_above_thr_i,
  input wire logic       vbus_valid_irq_o,
  input wire tci_cur_t   rd_thr_sel_o,
  input wire logic       source_role_i,
  input wire logic       role_ident_out_o,
  input wire tci_cur_t   cc_current_adv_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  logic live;
  // Pin follows the pending view one cycle late
  assign live = !ctrl_o[0] && |(int_flags_o & ~src_mask_i);
  chk_reset_vals: assert property (
    !$past(rst_n_i) |-> ctrl_o == TCI_CTRL_RST && mode_o == TCI_MODE_RST
    && !int_oe_o) else $error("reset values wrong");
  chk_mask_quiet: assert property (
    ctrl_o[0] && $past(ctrl_o[0]) |-> !int_oe_o) else $error("pin masked");
  chk_oe_raise: assert property (
    $past(live) |-> int_oe_o) else $error("pin not pulled");
  chk_oe_quiet: assert property (
    !$past(live) |-> !int_oe_o) else $error("pin pulled idle");
  chk_od_data: assert property (!int_n_o) else $error("pin data");
  chk_ident_pull: assert property (
    role_ident_out_oe_o == $past(type_reg_i[TCI_TYPE_SINK_BIT]))
    else $error("ident pin wrong");
  chk_addr_bit: assert property (
    slave_addr_o == (TCI_ADDR_BASE | {4'h0, $past(addr_select_pin_i, 3),
    3'h0})) else $error("address wrong");
  chk_vbus_edge: assert property (
    vbus_valid_irq_o == ($past(vbus_above_thr_i, 3)
    && !$past(vbus_above_thr_i, 4))) else $error("vbus event wrong");
  chk_thr_field: assert property (
    $stable(ctrl_o) |-> rd_thr_sel_o == ctrl_o[2:1])
    else $error("threshold select wrong");
  // Sink role never advertises, whatever the field holds
  chk_adv_role: assert property (
    cc_current_adv_o == ($past(source_role_i) ? $past(ctrl_o[2:1]) : 2'h0))
    else $error("advertisement wrong");
  chk_ident_data: assert property (!role_ident_out_o)
    else $error("ident pin data");
endmodule : tci_irq_ident_properties

bind tci_irq_ident tci_irq_ident_properties u_chk (.*);

// ===== tci_host_model.sv
// Host processor model: control writes and interrupt service
`timescale 1ns/1ps
module tci_host_model (
  input  wire logic       clk_i,
  input  wire logic       int_pin_i,
  output logic            ctrl_wr_o = 1'b0,
  output logic [7:0]      ctrl_wdata_o = 8'h00,
  output logic            mode_wr_o = 1'b0,
  output logic [7:0]      mode_wdata_o = 8'h00,
  output logic            int_read_o = 1'b0
);
  // Data lines invert once the strobe drops, stale data never lingers
  task automatic wr(input logic mode, input logic [7:0] d);
    @(negedge clk_i);
    ctrl_wr_o = !mode;
    mode_wr_o = mode;
    ctrl_wdata_o = d;
    mode_wdata_o = d;
    @(negedge clk_i);
    ctrl_wr_o = 1'b0;
    mode_wr_o = 1'b0;
    ctrl_wdata_o = ~d;
    mode_wdata_o = ~d;
  endtask : wr
  task automatic start_up(input logic [7:0] mode, input logic [7:0] ctrl);
    wr(1'b1, mode);
    wr(1'b0, ctrl);
  endtask : start_up
  task automatic serve_irq(input int lag, output logic ok);
    ok = 1'b0;
    for (int i = 0; i < 20 && !ok; i++) begin
      @(negedge clk_i);
      ok = (int_pin_i === 1'b0);
    end
    repeat (lag) @(negedge clk_i);
    int_read_o = ok;
    @(negedge clk_i);
    int_read_o = 1'b0;
  endtask : serve_irq
endmodule : tci_host_model

// ===== tb.sv
// Self-checking bench for the interrupt and ident block
`timescale 1ns/1ps
module tb;
  import tci_pkg::*;
  logic       clk_i = 1'b0;
  logic       rst_n_i = 1'b0;
  logic       source_role_i = 1'b0;
  logic       vbus_above_thr_i = 1'b0;
  logic       addr_select_pin_i = 1'b0;
  logic [3:0] evt = 4'h0;
  logic [7:0] type_reg_i = 8'h00;
  logic [4:0] src_mask_i = 5'h00;
  logic       ctrl_wr_i, mode_wr_i, int_read_i, int_n_o, int_oe_o;
  logic       role_ident_out_o, role_ident_out_oe_o, vbus_valid_irq_o;
  logic [7:0] ctrl_wdata_i, mode_wdata_i, ctrl_o, mode_o, slave_addr_o;
  logic [4:0] int_flags_o;
  tci_cur_t   cc_current_adv_o, rd_thr_sel_o;
  logic       ok;
  int         err_count = 0;
  int         n_compared = 0;
  // Open-drain pin with its pull-up
  wire        int_pin = int_oe_o ? int_n_o : 1'b1;
  always #12.5 clk_i = ~clk_i;
  tci_irq_ident dut (.*, .attach_evt_i(evt[0]), .detach_evt_i(evt[1]),
    .bc_lvl_evt_i(evt[2]), .acc_ch_evt_i(evt[3]));
  tci_host_model host (.clk_i(clk_i), .int_pin_i(int_pin),
    .ctrl_wr_o(ctrl_wr_i), .ctrl_wdata_o(ctrl_wdata_i),
    .mode_wr_o(mode_wr_i), .mode_wdata_o(mode_wdata_i),
    .int_read_o(int_read_i));
  task automatic chk(input string what, input logic [7:0] exp,
                     input logic [7:0] got);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(negedge clk_i);
  endtask : cyc
  task automatic pulse(input logic [3:0] e);
    evt = e;
    cyc(1);
    evt = 4'h0;
  endtask : pulse
  task automatic t_mask();
    chk("ctrl", TCI_CTRL_RST, ctrl_o);
    chk("mode", TCI_MODE_RST, mode_o);
    host.start_up(8'h01, 8'h00);
    cyc(4);
    chk("mode set", 8'h01, mode_o);
    chk("oe idle", 8'h00, int_oe_o);
    chk("pin data", 8'h00, int_n_o);
    host.wr(1'b0, 8'h01);
    pulse(4'h1);
    cyc(3);
    chk("flag", 8'h01, int_flags_o);
    chk("oe masked", 8'h00, int_oe_o);
    host.wr(1'b0, 8'h00);
    cyc(2);
    chk("oe late", 8'h01, int_oe_o);
    host.serve_irq(4, ok);
    chk("pin low", 8'h01, {7'h00, ok});
    cyc(3);
    chk("oe freed", 8'h00, int_oe_o);
  endtask : t_mask
  task automatic t_sources();
    for (int i = 0; i < 4; i++) begin
      src_mask_i = 5'h1f ^ (5'h01 << i);
      pulse(4'h1 << ((i + 1) % 4));
      cyc(3);
      chk("oe src masked", 8'h00, int_oe_o);
      pulse(4'h1 << i);
      cyc(3);
      chk("oe src", 8'h01, int_oe_o);
      host.serve_irq(2, ok);
      cyc(3);
      chk("flags read", 8'h00, int_flags_o);
    end
    src_mask_i = 5'h00;
  endtask : t_sources
  task automatic t_cur();
    source_role_i = 1'b1;
    for (int c = 0; c < 4; c++) begin
      host.wr(1'b0, {5'h00, c[1:0], 1'b0});
      cyc(3);
      chk("adv", {6'h00, c[1:0]}, cc_current_adv_o);
      chk("thr", {6'h00, c[1:0]}, rd_thr_sel_o);
    end
    source_role_i = 1'b0;
    cyc(3);
    chk("adv sink", 8'h00, cc_current_adv_o);
  endtask : t_cur
  task automatic t_pins();
    int n;
    n = 0;
    type_reg_i = 8'h10;
    addr_select_pin_i = 1'b1;
    cyc(4);
    chk("ident", 8'h01, role_ident_out_oe_o);
    chk("ident data", 8'h00, role_ident_out_o);
    chk("addr", TCI_ADDR_BASE | 8'h08, slave_addr_o);
    // Other type bits set must not pull the pin
    type_reg_i = 8'hef;
    addr_select_pin_i = 1'b0;
    vbus_above_thr_i = 1'b1;
    repeat (8) begin
      cyc(1);
      if (vbus_valid_irq_o === 1'b1) n++;
    end
    chk("ident off", 8'h00, role_ident_out_oe_o);
    chk("addr", TCI_ADDR_BASE, slave_addr_o);
    chk("vbus pulses", 8'h01, n[7:0]);
    chk("vbus flag", 8'h10, int_flags_o);
  endtask : t_pins
  // Mid-run reset with a flag pending; VBUS dropped first so no edge follows
  task automatic t_reset();
    vbus_above_thr_i = 1'b0;
    cyc(4);
    chk("oe pending", 8'h01, int_oe_o);
    rst_n_i = 1'b0;
    cyc(3);
    rst_n_i = 1'b1;
    cyc(3);
    chk("ctrl rst", TCI_CTRL_RST, ctrl_o);
    chk("mode rst", TCI_MODE_RST, mode_o);
    chk("oe rst", 8'h00, int_oe_o);
    chk("flags rst", 8'h00, int_flags_o);
  endtask : t_reset
  task automatic print_verdict();
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : print_verdict
  initial begin
    repeat (3000) @(posedge clk_i);
    err_count++;
    print_verdict();
  end
  initial begin
    cyc(4);
    rst_n_i = 1'b1;
    cyc(3);
    t_mask();
    t_sources();
    t_cur();
    t_pins();
    t_reset();
    print_verdict();
  end
endmodule : tb
